// File: design/gpp_lock_seq.sv
// write-protect arming sequencer: write 1, write 0, write 1, read
`timescale 1ns/1ps
module gpp_lock_seq
	import gpp_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	gpp_link_if.lock_mp lk
);
	gpp_lock_state_t state_reg, state_next;
	logic [15:0]     pend_reg, pend_next;
	logic            active_reg, active_next;
	logic [15:0]     lmask_reg, lmask_next;
	logic            seq_bit, same;

	assign seq_bit = lk.wdata[LOCK_SEQ_BIT];
	assign same    = lk.wdata[15:0] == pend_reg;

	// ------------------------------------------------------------
	// sequence tracking
	// ------------------------------------------------------------
	always_comb begin
		state_next  = state_reg;
		pend_next   = pend_reg;
		active_next = active_reg;
		lmask_next  = lmask_reg;
		// any wrong write restarts; a read out of turn is ignored; a fresh 1 may open a new attempt
		if (!active_reg && lk.wr_stb) begin
			state_next = seq_bit ? LK_ONE : LK_IDLE;
			pend_next  = lk.wdata[15:0];
			case (state_reg)
				LK_ONE: if (!seq_bit && same) state_next = LK_ZERO;
				LK_ZERO: if (seq_bit && same) state_next = LK_AGAIN;
				default: ;
			endcase
		end else if (!active_reg && lk.rd_stb &&
				state_reg == LK_AGAIN) begin
			active_next = 1'b1;
			lmask_next  = pend_reg;
			state_next  = LK_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg  <= LK_IDLE;
			pend_reg   <= HALF_RST;
			active_reg <= 1'b0;
			lmask_reg  <= HALF_RST;
		end else begin
			state_reg  <= state_next;
			pend_reg   <= pend_next;
			active_reg <= active_next;
			lmask_reg  <= lmask_next;
		end
	end

	assign lk.active    = active_reg;
	assign lk.lock_mask = lmask_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_arm_after_read: assert property ($rose(active_reg) |->
		$past(lk.rd_stb) && $past(state_reg) == LK_AGAIN)
		else $error("lock armed without the full sequence");
	a_lock_sticky: assert property (active_reg |=>
		active_reg && $stable(lmask_reg))
		else $error("lock dropped before reset");
	c_lock_armed: cover property ($rose(active_reg));
endmodule

// File: design/gpp_pin_mux.sv
// per-pin choice between output level and alternate function
`timescale 1ns/1ps
module gpp_pin_mux
	import gpp_pkg::*;
(
	gpp_link_if.mux_mp mx
);
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		logic [1:0] mode;
		logic [3:0] sel;
		logic       fn;
		assign mode = mx.mode[2*i +: 2];
		if (i < 8) begin : g_lo
			assign sel = mx.muxl[4*i +: 4];
		end else begin : g_hi
			assign sel = mx.muxh[4*(i-8) +: 4];
		end
		assign fn = mx.alt_out[FUNC_N*i + int'(sel[2:0])];
		// reserved codes 1xxx leave the pin undriven
		assign mx.pin_drive[i] = (mode == MODE_MUX) ?
			fn : mx.out_level[i];
		assign mx.pin_oe[i] = (mode == MODE_OUT) ||
			(mode == MODE_MUX && !sel[3]);
	end
endmodule

// File: design/gpp_port.sv
// sixteen-pin gpio port with Avalon-MM register slave
// Operation
// - each pin has a two-bit pull field, 00 none, 01 pull-up, 10 down.
// - pull register resets to 0x24000000 on the first port, else zero.
// - input register shows the sixteen pin levels, upper half zero.
// - output register holds one level per pin, reset zero, 1 is high.
// - a 1 in bit 16+y of the set/clear register clears output bit y unless bit y is also 1.
// - a 1 in bit y of the set/clear register sets output bit y.
// - a 1 in bit y of the clear-only register clears output bit y.
// - the lock register holds a per-pin protect mask in bits 15:0.
// - lock arms after writes of bit 16 as 1, 0, 1 then a read.
// - pins 0-7 take a four-bit function select from the low register.
// - pins 8-15 take the same kind of select from the high register.
// - the low function register sits at 0x20 and resets to zero.
// - a selected function drives the pin only in mode 10.
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
#(
	parameter bit FIRST_PORT = 1'b0
)(
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic [5:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	input  wire logic [15:0]  pin_in,
	input  wire logic [127:0] alt_func_out,
	output logic      [15:0]  pin_out,
	output logic      [15:0]  pin_oe,
	output logic      [15:0]  pin_pull_up,
	output logic      [15:0]  pin_pull_down
);
	localparam logic [31:0] MODE_RST = FIRST_PORT ? MODE_RST_FIRST : REG_RST;
	localparam logic [31:0] PULL_RST = FIRST_PORT ? PULL_RST_FIRST : REG_RST;

	gpp_link_if lk ();

	logic        wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] mode_reg, mode_next;
	logic [31:0] pull_reg, pull_next;
	logic [31:0] muxl_reg, muxl_next;
	logic [31:0] muxh_reg, muxh_next;
	logic [15:0] out_lvl_reg, out_lvl_next;
	logic [16:0] wpr_reg, wpr_next;
	logic [15:0] in_lvl_reg, pout_reg, poe_reg, pu_reg, pd_reg;
	logic [15:0] pu_w, pd_w;

	logic [5:0]  addr;
	logic        wr_acc, rd_acc;
	logic [31:0] bmask, wd;
	logic [31:0] prot2, protl, proth;
	logic [15:0] set_b, clr_b, out_lvl_base;
	logic [31:0] rd_mux;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] keep);
		merge = (old_v & keep) | (new_v & ~keep);
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign addr   = {avs_address[5:2], 2'b00};
	assign wr_acc = avs_write && !wait_reg;
	assign rd_acc = avs_read && !wait_reg;
	assign bmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wd     = avs_writedata & bmask;

	// per-pin protection spread over two- and four-bit fields
	for (genvar i = 0; i < PIN_N; i++) begin : g_prot
		logic p;
		assign p = lk.active && lk.lock_mask[i];
		assign prot2[2*i +: 2] = {2{p}};
		if (i < 8) begin : g_lo
			assign protl[4*i +: 4] = {4{p}};
		end else begin : g_hi
			assign proth[4*(i-8) +: 4] = {4{p}};
		end
		assign pu_w[i] = pull_reg[2*i +: 2] == PULL_UP;
		assign pd_w[i] = pull_reg[2*i +: 2] == PULL_DOWN;
	end

	always_comb begin
		case (addr)
			OFF_MODE: rd_mux = mode_reg;
			OFF_PULL: rd_mux = pull_reg;
			OFF_IN_LVL:  rd_mux = {HALF_RST, in_lvl_reg};
			OFF_OUT_LVL: rd_mux = {HALF_RST, out_lvl_reg};
			OFF_WPR:  rd_mux = {15'h0000, wpr_reg};
			OFF_MUXL: rd_mux = muxl_reg;
			OFF_MUXH: rd_mux = muxh_reg;
			default:  rd_mux = REG_RST;
		endcase
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_comb begin
		// one wait state: answer follows the first cycle of a request
		wait_next  = !((avs_read || avs_write) && wait_reg);
		rdata_next = (avs_read && wait_reg) ? rd_mux : rdata_reg;
		mode_next  = mode_reg;
		pull_next  = pull_reg;
		muxl_next  = muxl_reg;
		muxh_next  = muxh_reg;
		wpr_next   = wpr_reg;
		out_lvl_base = out_lvl_reg;
		set_b      = HALF_RST;
		clr_b      = HALF_RST;
		if (wr_acc) begin
			case (addr)
				OFF_MODE: mode_next = merge(mode_reg, wd,
					~bmask | prot2);
				OFF_PULL: pull_next = merge(pull_reg, wd,
					~bmask | prot2);
				OFF_OUT_LVL: out_lvl_base = (out_lvl_reg & ~bmask[15:0]) |
					(wd[15:0] & bmask[15:0]);
				OFF_SCR: begin
					set_b = wd[15:0];
					clr_b = wd[31:16];
				end
				OFF_CLR: clr_b = wd[15:0];
				OFF_WPR: if (!lk.active)
					wpr_next = (wpr_reg & ~bmask[16:0]) |
						(wd[16:0] & bmask[16:0]);
				OFF_MUXL: muxl_next = merge(muxl_reg, wd,
					~bmask | protl);
				OFF_MUXH: muxh_next = merge(muxh_reg, wd,
					~bmask | proth);
				default: ;
			endcase
		end
		out_lvl_next = (out_lvl_base & ~clr_b) | set_b;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wait_reg  <= 1'b1;
			rdata_reg <= REG_RST;
			mode_reg  <= MODE_RST;
			pull_reg  <= PULL_RST;
			muxl_reg  <= REG_RST;
			muxh_reg  <= REG_RST;
			out_lvl_reg <= HALF_RST;
			wpr_reg   <= WPR_RST;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			mode_reg  <= mode_next;
			pull_reg  <= pull_next;
			muxl_reg  <= muxl_next;
			muxh_reg  <= muxh_next;
			out_lvl_reg <= out_lvl_next;
			wpr_reg   <= wpr_next;
		end
	end

	// ------------------------------------------------------------
	// lock sequencer and pin mux
	// ------------------------------------------------------------
	assign lk.wr_stb    = wr_acc && addr == OFF_WPR;
	assign lk.rd_stb    = rd_acc && addr == OFF_WPR;
	assign lk.wdata     = wd[16:0];
	assign lk.mode      = mode_reg;
	assign lk.muxl      = muxl_reg;
	assign lk.muxh      = muxh_reg;
	assign lk.out_level = out_lvl_reg;
	assign lk.alt_out   = alt_func_out;

	gpp_lock_seq u_lock (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.lk      (lk.lock_mp)
	);

	gpp_pin_mux u_mux (
		.mx (lk.mux_mp)
	);

	// ------------------------------------------------------------
	// pin-facing registers
	// ------------------------------------------------------------
	// pins arrive synchronous; one stage aligns them with bus reads
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			in_lvl_reg <= HALF_RST;
			pout_reg <= HALF_RST;
			poe_reg  <= HALF_RST;
			pu_reg   <= HALF_RST;
			pd_reg   <= HALF_RST;
		end else begin
			in_lvl_reg <= pin_in;
			pout_reg <= lk.pin_drive;
			poe_reg  <= lk.pin_oe;
			pu_reg   <= pu_w;
			pd_reg   <= pd_w;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign pin_out         = pout_reg;
	assign pin_oe          = poe_reg;
	assign pin_pull_up     = pu_reg;
	assign pin_pull_down   = pd_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_pull_reset: assert property ($fell(sys_rst) |->
		pull_reg == PULL_RST && muxl_reg == REG_RST)
		else $error("pull or function register reset value wrong");
	a_wait_one: assert property ((avs_read || avs_write) && wait_reg
		|=> !wait_reg ##1 wait_reg)
		else $error("waitrequest not low for exactly one cycle");
	a_in_read: assert property (avs_read && wait_reg &&
		addr == OFF_IN_LVL
		|=> rdata_reg == {HALF_RST, $past(in_lvl_reg)})
		else $error("input level readback wrong");
	a_scr_set: assert property (wr_acc && addr == OFF_SCR
		|=> (out_lvl_reg & $past(wd[15:0])) == $past(wd[15:0]))
		else $error("set/clear write did not set bits");
	a_scr_clr: assert property (wr_acc && addr == OFF_SCR |=>
		(out_lvl_reg & $past(wd[31:16] & ~wd[15:0])) == 16'h0000)
		else $error("set/clear write did not clear bits");
	a_clr_only: assert property (wr_acc && addr == OFF_CLR
		|=> (out_lvl_reg & $past(wd[15:0])) == 16'h0000)
		else $error("clear-only write did not clear bits");
	a_out_hold: assert property (!(wr_acc &&
		(addr == OFF_OUT_LVL || addr == OFF_SCR || addr == OFF_CLR))
		|=> $stable(out_lvl_reg))
		else $error("output level changed without a write");
	a_out_write: assert property (wr_acc && addr == OFF_OUT_LVL &&
		avs_byteenable == 4'hF
		|=> out_lvl_reg == $past(avs_writedata[15:0]))
		else $error("full output level write did not land");
	a_lock_pull: assert property (lk.active && wr_acc &&
		addr == OFF_PULL |=> ((pull_reg ^ $past(pull_reg)) &
		$past(prot2)) == REG_RST)
		else $error("locked pin pull field changed");
	a_pin0_out: assert property (mode_reg[1:0] == MODE_OUT
		|=> pin_out[0] == $past(out_lvl_reg[0]) && pin_oe[0])
		else $error("pin 0 does not follow its output level");
	a_pin0_alt: assert property (mode_reg[1:0] == MODE_MUX &&
		muxl_reg[3] == 1'b0 |=> pin_out[0] ==
		$past(alt_func_out[muxl_reg[2:0]]))
		else $error("pin 0 does not follow its alternate function");

	// ------------------------------------------------------------
	// pin-side checks on the first pin of each half
	// ------------------------------------------------------------
	a_pin8_alt: assert property (mode_reg[17:16] == MODE_MUX &&
		muxh_reg[3] == 1'b0 |=> pin_out[8] ==
		$past(alt_func_out[64 + int'(muxh_reg[2:0])]))
		else $error("pin 8 does not follow its alternate function");
	a_rsvd_float: assert property (mode_reg[1:0] == MODE_MUX &&
		muxl_reg[3] |=> !pin_oe[0])
		else $error("reserved function code drives pin 0");
	a_input_float: assert property (mode_reg[1:0] == 2'h0
		|=> !pin_oe[0])
		else $error("pin 0 driven in input mode");
	a_pull_up_pin: assert property (pull_reg[1:0] == PULL_UP
		|=> pin_pull_up[0] && !pin_pull_down[0])
		else $error("pin 0 pull-up not applied");
	a_pull_dn_pin: assert property (pull_reg[1:0] == PULL_DOWN
		|=> pin_pull_down[0] && !pin_pull_up[0])
		else $error("pin 0 pull-down not applied");
	a_pull_none: assert property (pull_reg[1:0] == 2'h0
		|=> !pin_pull_up[0] && !pin_pull_down[0])
		else $error("pin 0 pull applied without request");

	// ------------------------------------------------------------
	// lock and reset checks
	// ------------------------------------------------------------
	// a locked pin must keep every protected field, whatever is written
	a_lock_fields: assert property (lk.active && lk.lock_mask[0]
		|=> $stable(muxl_reg[3:0]) && $stable(pull_reg[1:0]) &&
		$stable(mode_reg[1:0]))
		else $error("locked pin 0 field changed");
	a_lock_reg: assert property (lk.active && wr_acc &&
		addr == OFF_WPR |=> $stable(wpr_reg))
		else $error("lock register written while locked");
	a_bus_reset: assert property ($fell(sys_rst)
		|-> wait_reg && rdata_reg == REG_RST)
		else $error("bus outputs not at reset values");

	c_scr_both: cover property (wr_acc && addr == OFF_SCR &&
		(wd[15:0] & wd[31:16]) != 16'h0000);
	c_locked_wr: cover property (lk.active && wr_acc && addr == OFF_MUXL);
	c_alt_drive: cover property (mode_reg[1:0] == MODE_MUX && pin_oe[0]);
	c_pin8_alt: cover property (mode_reg[17:16] == MODE_MUX && pin_oe[8]);
endmodule

// File: pkg/gpp_link_if.sv
// signals between the port core, its lock sequencer and its pin mux
`timescale 1ns/1ps
interface gpp_link_if;
	logic         wr_stb;
	logic         rd_stb;
	logic [16:0]  wdata;
	logic         active;
	logic [15:0]  lock_mask;
	logic [31:0]  mode;
	logic [31:0]  muxl;
	logic [31:0]  muxh;
	logic [15:0]  out_level;
	logic [127:0] alt_out;
	logic [15:0]  pin_drive;
	logic [15:0]  pin_oe;

	modport lock_mp (input wr_stb, rd_stb, wdata,
		output active, lock_mask);
	modport mux_mp (input mode, muxl, muxh, out_level, alt_out,
		output pin_drive, pin_oe);
	modport core_mp (output wr_stb, rd_stb, wdata, mode, muxl, muxh,
		out_level, alt_out, input active, lock_mask, pin_drive, pin_oe);
endinterface

// File: pkg/gpp_pkg.sv
// constants and types shared by the gpio port block
package gpp_pkg;
	localparam int PIN_N  = 16;
	localparam int FUNC_N = 8;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFF_MODE = 6'h00;
	localparam logic [5:0] OFF_PULL = 6'h0C;
	localparam logic [5:0] OFF_IN_LVL  = 6'h10;
	localparam logic [5:0] OFF_OUT_LVL = 6'h14;
	localparam logic [5:0] OFF_SCR  = 6'h18;
	localparam logic [5:0] OFF_WPR  = 6'h1C;
	localparam logic [5:0] OFF_MUXL = 6'h20;
	localparam logic [5:0] OFF_MUXH = 6'h24;
	localparam logic [5:0] OFF_CLR  = 6'h28;

	// ------------------------------------------------------------
	// reset values and field codes
	// ------------------------------------------------------------
	localparam logic [31:0] MODE_RST_FIRST = 32'h2800_0000;
	localparam logic [31:0] PULL_RST_FIRST = 32'h2400_0000;
	localparam logic [31:0] REG_RST        = 32'h0000_0000;
	localparam logic [15:0] HALF_RST       = 16'h0000;
	localparam logic [16:0] WPR_RST        = 17'h0_0000;
	localparam int          LOCK_SEQ_BIT   = 16;
	localparam logic [1:0]  MODE_OUT       = 2'h1;
	localparam logic [1:0]  MODE_MUX       = 2'h2;
	localparam logic [1:0]  PULL_UP        = 2'h1;
	localparam logic [1:0]  PULL_DOWN      = 2'h2;

	typedef enum logic [3:0] {
		LK_IDLE  = 4'h1,
		LK_ONE   = 4'h2,
		LK_ZERO  = 4'h4,
		LK_AGAIN = 4'h8
	} gpp_lock_state_t;
endpackage

// File: verification/gpp_pin_model.sv
// pin-side model: pulls, loopback of driven pins, floating pins
`timescale 1ns/1ps
module gpp_pin_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] pin_pull_up,
	input  wire logic [15:0] pin_pull_down,
	output logic      [15:0] pin_in
);
	logic [15:0] float_reg;

	// a floating pin wanders, so nothing may lean on its level
	initial float_reg = 16'h5A5A;
	always @(posedge ref_clk) float_reg <= ~float_reg;

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (pin_pull_up[i])
				pin_in[i] = 1'b1;
			else if (pin_pull_down[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = float_reg[i];
		end
	end
endmodule

// File: verification/test_gpio_port_pull_data_mux_protect.sv
// self-checking bench for the gpio port register block
`timescale 1ns/1ps
module test_gpio_port_pull_data_mux_protect
	import gpp_pkg::*;
;
	logic         ref_clk;
	logic         sys_rst;
	logic [5:0]   avs_address;
	logic         avs_read;
	logic         avs_write;
	logic [31:0]  avs_writedata;
	logic [3:0]   avs_byteenable;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	logic [15:0]  pin_in;
	logic [127:0] alt_func_out;
	logic [15:0]  pin_out;
	logic [15:0]  pin_oe;
	logic [15:0]  pin_pull_up;
	logic [15:0]  pin_pull_down;
	logic [31:0]  rd;
	int           mismatches;
	int           comparisons;

	gpp_port #(.FIRST_PORT(1'b1)) uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
		.alt_func_out(alt_func_out), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
		.pin_pull_down(pin_pull_down));

	gpp_pin_model pins (
		.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
		.pin_in(pin_in));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// report and bus helpers
	// ----------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what,
				seen, exp);
		end
	endtask

	// one request, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		@(posedge ref_clk);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] exp,
		input string what);
		bus(1'b0, a, 32'h0000_0000);
		check(rd, exp, what);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdc(OFF_PULL, PULL_RST_FIRST, "pull reset");
		rdc(OFF_OUT_LVL, REG_RST, "output reset");
		rdc(OFF_MUXL, REG_RST, "func low reset");
		rdc(OFF_MUXH, REG_RST, "func high reset");
		check({pin_pull_down, pin_pull_up}, 32'h4000_2000, "pulls");
	endtask

	task automatic t_pull;
		bus(1'b1, OFF_MODE, REG_RST);
		bus(1'b1, OFF_PULL, 32'h0000_0009);
		rdc(OFF_PULL, 32'h0000_0009, "pull readback");
		check({pin_pull_down, pin_pull_up}, 32'h0002_0001, "pull");
		bus(1'b0, OFF_IN_LVL, 32'h0000_0000);
		check(rd & 32'hFFFF_0003, 32'h0000_0001, "pulled input");
	endtask

	task automatic t_output;
		bus(1'b1, OFF_MODE, 32'h5555_5555);
		bus(1'b1, OFF_OUT_LVL, 32'hFFFF_A5C3);
		rdc(OFF_OUT_LVL, 32'h0000_A5C3, "output readback");
		check({pin_oe, pin_out}, 32'hFFFF_A5C3, "driven pins");
		rdc(OFF_IN_LVL, 32'h0000_A5C3, "input loopback");
	endtask

	task automatic t_setclr;
		bus(1'b1, OFF_OUT_LVL, 32'h0000_00F0);
		bus(1'b1, OFF_SCR, 32'h0030_000F);
		rdc(OFF_OUT_LVL, 32'h0000_00CF, "set and clear");
		bus(1'b1, OFF_SCR, 32'h0101_0100);
		rdc(OFF_OUT_LVL, 32'h0000_01CE, "set beats clear");
		rdc(OFF_SCR, REG_RST, "set/clear reads zero");
		bus(1'b1, OFF_CLR, 32'hFFFF_0003);
		rdc(OFF_OUT_LVL, 32'h0000_01CC, "clear only");
		check({16'h0000, pin_out}, 32'h0000_01CC, "pins");
	endtask

	task automatic t_mux;
		logic [127:0] pat;
		pat = '0;
		// every code 0..7 used once in each half
		for (int i = 0; i < 16; i++)
			pat[8*i + ((i < 8) ? i : 15 - i)] = 1'b1;
		bus(1'b1, OFF_MUXL, 32'h7654_3210);
		bus(1'b1, OFF_MUXH, 32'h0123_4567);
		bus(1'b1, OFF_MODE, 32'hAAAA_AAAA);
		alt_func_out <= pat;
		rdc(OFF_MUXL, 32'h7654_3210, "func low readback");
		check({pin_oe, pin_out}, 32'hFFFF_FFFF, "funcs high");
		alt_func_out <= ~pat;
		rdc(OFF_MUXH, 32'h0123_4567, "func high readback");
		check({pin_oe, pin_out}, 32'hFFFF_0000, "funcs low");
		bus(1'b1, OFF_MUXL, 32'h7654_3218);
		@(posedge ref_clk);
		check({16'h0000, pin_oe}, 32'h0000_FFFE, "reserved code");
		alt_func_out <= pat;
		bus(1'b1, OFF_MUXL, 32'h7654_3210);
		bus(1'b1, OFF_MODE, 32'hAAAA_AAA9);
		@(posedge ref_clk);
		check({pin_oe, pin_out}, 32'hFFFF_FFFE, "output mode");
	endtask

	task automatic t_lock;
		bus(1'b1, OFF_PULL, REG_RST);
		// two starts then a read: must not arm
		bus(1'b1, OFF_WPR, 32'h0001_0003);
		bus(1'b1, OFF_WPR, 32'h0001_0003);
		bus(1'b0, OFF_WPR, 32'h0000_0000);
		bus(1'b1, OFF_PULL, 32'h0000_0005);
		rdc(OFF_PULL, 32'h0000_0005, "not armed");
		bus(1'b1, OFF_WPR, 32'h0001_0003);
		bus(1'b1, OFF_WPR, 32'h0000_0003);
		bus(1'b1, OFF_WPR, 32'h0001_0003);
		bus(1'b0, OFF_WPR, 32'h0000_0000);
		bus(1'b1, OFF_PULL, 32'h0000_00FF);
		rdc(OFF_PULL, 32'h0000_00F5, "masked pull kept");
		bus(1'b1, OFF_MUXL, 32'hFFFF_FFFF);
		rdc(OFF_MUXL, 32'hFFFF_FF10, "masked func kept");
		bus(1'b1, OFF_WPR, 32'h0000_0000);
		rdc(OFF_WPR, 32'h0001_0003, "lock write refused");
		// only a reset lifts the lock
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rdc(OFF_PULL, PULL_RST_FIRST, "pull after reset");
		bus(1'b1, OFF_PULL, 32'h0000_00FF);
		rdc(OFF_PULL, 32'h0000_00FF, "lock gone");
	endtask

	initial begin
		mismatches = 0;
		comparisons = 0;
		sys_rst        <= 1'b1;
		avs_address    <= 6'h00;
		avs_read       <= 1'b0;
		avs_write      <= 1'b0;
		avs_writedata  <= 32'h0000_0000;
		avs_byteenable <= 4'hF;
		alt_func_out   <= '0;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_pull();
		t_output();
		t_setclr();
		t_mux();
		t_lock();
		wrap_up();
	end
endmodule
